// ---- verilog/mbx_pkg.sv ----
// Package of constants for the parallel slave mailbox port
package mbx_pkg;
   // Local register offsets
   localparam logic [7:0] OFS_BYTE_0 = 8'h20;
   localparam logic [7:0] OFS_BYTE_1 = 8'h21;
   localparam logic [7:0] OFS_BYTE_2 = 8'h22;
   localparam logic [7:0] OFS_STATUS = 8'h23;
   localparam logic [7:0] OFS_CONTROL = 8'h24;
   // Master slot codes
   localparam logic [1:0] SLOT_0 = 2'h0;
   localparam logic [1:0] SLOT_1 = 2'h1;
   localparam logic [1:0] SLOT_2 = 2'h2;
   localparam logic [1:0] SLOT_STATUS = 2'h3;
   // Status fields
   localparam int ST_MASTER_WROTE = 7;
   localparam int ST_IN_LO = 4;
   localparam int ST_LOCAL_WROTE = 3;
   localparam int ST_OUT_LO = 0;
   localparam logic [7:0] STATUS_RESET = 8'h00;
   // Control fields
   localparam int CT_FETCH = 7;
   localparam int CT_BOOT_HI = 6;
   localparam int CT_BOOT_LO = 5;
   localparam int CT_ALT_SEL = 4;
   localparam int CT_MODE_HI = 3;
   localparam int CT_MODE_LO = 2;
   localparam int CT_PRI_HI = 1;
   localparam int CT_PRI_LO = 0;
   localparam logic [1:0] MODE_PORT_IN = 2'h0;
   localparam logic [1:0] MODE_PORT_OUT = 2'h1;
   localparam logic [1:0] MODE_SLAVE = 2'h2;
   localparam logic [1:0] MODE_IO_BUS = 2'h3;
   localparam logic [1:0] PRI_OFF = 2'h0;
   localparam logic [11:0] INT_VECTOR_OFS = 12'h080;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ACTIVE = 2'b01,
      ST_DONE = 2'b11
   } mbx_strobe_t;
endpackage

// ---- verilog/mbx_sync.sv ----
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
`default_nettype none
module mbx_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '1
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;
   always_ff @(posedge clock) begin
      if (rst) begin
         meta <= INIT;
         q <= INIT;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// ---- verilog/mbx_strobe.sv ----
// Strobe tracker: one pulse at the start and one at the end of a strobe
`timescale 1ns/1ns
`default_nettype none
module mbx_strobe
   import mbx_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic active,
   output logic start,
   output logic finish
);
   mbx_strobe_t state;
   mbx_strobe_t next_state;
   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (active) next_state = ST_ACTIVE;
         end
         ST_ACTIVE: begin
            if (!active) next_state = ST_DONE;
         end
         ST_DONE: begin
            next_state = active ? ST_ACTIVE : ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end
   assign start = (state != ST_ACTIVE) && active;
   assign finish = (state == ST_ACTIVE) && !active;
   always_ff @(posedge clock) begin
      if (rst) state <= ST_IDLE;
      else state <= next_state;
   end
endmodule
`default_nettype wire

// ---- verilog/mbx_port.sv ----
// Parallel slave mailbox port: master pins and local register port
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none
module mbx_port
   import mbx_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   // Local register port
   input wire logic [7:0] reg_addr,
   input wire logic reg_read,
   input wire logic reg_write,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Master pins
   input wire logic [7:0] port_bus_in,
   output logic [7:0] port_bus_out,
   output logic port_bus_oe_n,
   input wire logic [1:0] port_addr,
   input wire logic port_read_n,
   input wire logic port_write_n,
   input wire logic port_select_n,
   input wire logic alt_select_n,
   output logic attention_out_n,
   // Mode pins and system side
   input wire logic [1:0] boot_select_pins,
   output logic port_enabled,
   output logic port_pins_own,
   output logic [1:0] pin_mode,
   output logic ignore_boot_pins,
   output logic irq,
   output logic [1:0] irq_priority,
   output logic [11:0] irq_vector
);
   import mbx_pkg::*;

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [5:0] pins_raw;
   logic [5:0] pins_s;
   logic [7:0] bus_s;
   logic [1:0] boot_s;
   assign pins_raw = {port_addr, port_read_n, port_write_n, port_select_n, alt_select_n};
   mbx_sync #(.WIDTH(6), .INIT(6'h3f)) u_sync_pins (
      .clock(clock),
      .rst(rst),
      .d(pins_raw),
      .q(pins_s)
   );
   mbx_sync #(.WIDTH(8), .INIT(8'h00)) u_sync_bus (
      .clock(clock),
      .rst(rst),
      .d(port_bus_in),
      .q(bus_s)
   );
   mbx_sync #(.WIDTH(2), .INIT(2'h0)) u_sync_boot (
      .clock(clock),
      .rst(rst),
      .d(boot_select_pins),
      .q(boot_s)
   );

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   logic ctl_fetch;
   logic ctl_alt;
   logic [1:0] ctl_mode;
   logic [1:0] ctl_pri;
   wire l_sel_byte0 = reg_addr == OFS_BYTE_0;
   wire l_sel_byte1 = reg_addr == OFS_BYTE_1;
   wire l_sel_byte2 = reg_addr == OFS_BYTE_2;
   wire l_sel_stat = reg_addr == OFS_STATUS;
   wire l_sel_ctl = reg_addr == OFS_CONTROL;
   wire l_sel_any = l_sel_byte0 | l_sel_byte1 | l_sel_byte2 | l_sel_stat;
   always_ff @(posedge clock) begin
      if (rst) begin
         ctl_fetch <= 1'b0;
         ctl_alt <= 1'b0;
         ctl_mode <= MODE_PORT_IN;
         ctl_pri <= PRI_OFF;
      end else if (reg_write && l_sel_ctl) begin
         ctl_fetch <= reg_wdata[CT_FETCH];
         ctl_alt <= reg_wdata[CT_ALT_SEL];
         ctl_mode <= reg_wdata[CT_MODE_HI:CT_MODE_LO];
         ctl_pri <= reg_wdata[CT_PRI_HI:CT_PRI_LO];
      end
   end
   wire enabled = ctl_mode == MODE_SLAVE;
   assign port_enabled = enabled;
   assign port_pins_own = enabled;
   assign pin_mode = ctl_mode;
   assign ignore_boot_pins = ctl_fetch;

   // ------------------------------------------------------------
   // Master access decode
   // ------------------------------------------------------------
   logic [1:0] m_addr;
   logic m_rd;
   logic m_wr;
   logic m_cs;
   logic [1:0] m_addr_q;
   logic rd_start;
   logic rd_end;
   logic wr_start;
   logic wr_end;
   assign m_addr = pins_s[5:4];
   assign m_cs = enabled && !(ctl_alt ? pins_s[0] : pins_s[1]);
   assign m_rd = m_cs && !pins_s[3];
   assign m_wr = m_cs && !pins_s[2];
   mbx_strobe u_rd (
      .clock(clock),
      .rst(rst),
      .active(m_rd),
      .start(rd_start),
      .finish(rd_end)
   );
   mbx_strobe u_wr (
      .clock(clock),
      .rst(rst),
      .active(m_wr),
      .start(wr_start),
      .finish(wr_end)
   );
   always_ff @(posedge clock) begin
      if (rst) m_addr_q <= SLOT_0;
      else if (rd_start || wr_start) m_addr_q <= m_addr;
   end
   logic [7:0] wr_data_q;
   always_ff @(posedge clock) begin
      if (wr_start || m_wr) wr_data_q <= bus_s;
   end
   // Read ends empty the slot; write ends commit the captured byte
   wire m_rd_done = rd_end;
   wire m_wr_done = wr_end;
   wire m_stat = m_addr_q == SLOT_STATUS;
   wire m_access = rd_start || wr_start;

   // ------------------------------------------------------------
   // Mailbox bytes and flags
   // ------------------------------------------------------------
   logic [7:0] in_byte [3];
   logic [7:0] out_byte [3];
   logic [2:0] in_full;
   logic [2:0] out_full;
   logic master_wrote;
   logic local_wrote;
   logic [2:0] l_slot;
   assign l_slot = {l_sel_byte2, l_sel_byte1, l_sel_byte0};

   function automatic logic [2:0] slot_hot(input logic [1:0] a);
      slot_hot = (a == SLOT_STATUS) ? 3'h0 : 3'(3'h1 << a);
   endfunction

   wire [2:0] m_wr_hot = m_wr_done ? slot_hot(m_addr_q) : 3'h0;
   wire [2:0] m_rd_hot = m_rd_done ? slot_hot(m_addr_q) : 3'h0;
   wire [2:0] l_wr_hot = reg_write ? l_slot : 3'h0;
   wire [2:0] l_rd_hot = reg_read ? l_slot : 3'h0;

   // Set wins over clear on every flag
   always_ff @(posedge clock) begin
      if (rst) begin
         in_full <= 3'h0;
         out_full <= 3'h0;
      end else begin
         in_full <= (in_full & ~l_rd_hot) | m_wr_hot;
         out_full <= (out_full & ~m_rd_hot) | l_wr_hot;
      end
   end

   always_ff @(posedge clock) begin
      for (int i = 0; i < 3; i++) begin
         if (m_wr_hot[i]) in_byte[i] <= wr_data_q;
         if (l_wr_hot[i]) out_byte[i] <= reg_wdata;
      end
   end

   // ------------------------------------------------------------
   // Event bits: attention and local request
   // ------------------------------------------------------------
   wire l_access = (reg_read || reg_write) && l_sel_any;
   wire any_access = l_access || m_access;
   wire master_slot0 = m_wr_done && m_addr_q == SLOT_0;
   wire local_slot0 = reg_write && l_sel_byte0;
   always_ff @(posedge clock) begin
      if (rst) begin
         master_wrote <= 1'b0;
         local_wrote <= 1'b0;
      end else begin
         // Ordinary accesses clear, slot 0 writes set; set wins
         if (master_slot0) master_wrote <= 1'b1;
         else if (any_access || (reg_write && l_sel_stat)) master_wrote <= 1'b0;
         if (local_slot0) local_wrote <= 1'b1;
         else if (any_access || (m_wr_done && m_stat)) local_wrote <= 1'b0;
      end
   end

   logic [7:0] status;
   always_comb begin
      status = STATUS_RESET;
      status[ST_MASTER_WROTE] = master_wrote;
      status[ST_IN_LO +: 3] = in_full;
      status[ST_LOCAL_WROTE] = local_wrote;
      status[ST_OUT_LO +: 3] = out_full;
   end

   assign irq = master_wrote && (ctl_pri != PRI_OFF);
   assign irq_priority = ctl_pri;
   assign irq_vector = INT_VECTOR_OFS;
   assign attention_out_n = !(local_wrote && enabled);

   // ------------------------------------------------------------
   // Read data paths
   // ------------------------------------------------------------
   logic [7:0] ctl_view;
   always_comb begin
      ctl_view = 8'h00;
      ctl_view[CT_FETCH] = ctl_fetch;
      ctl_view[CT_BOOT_HI:CT_BOOT_LO] = boot_s;
      ctl_view[CT_ALT_SEL] = ctl_alt;
   end
   wire [7:0] l_rd_mux = l_sel_byte0 ? in_byte[0] :
                         l_sel_byte1 ? in_byte[1] :
                         l_sel_byte2 ? in_byte[2] :
                         l_sel_stat ? status :
                         l_sel_ctl ? ctl_view : 8'h00;
   always_ff @(posedge clock) begin
      if (rst) reg_rdata <= 8'h00;
      else if (reg_read) reg_rdata <= l_rd_mux;
   end

   wire [7:0] m_rd_mux = (m_addr == SLOT_STATUS) ? status :
                         (m_addr == SLOT_2) ? out_byte[2] :
                         (m_addr == SLOT_1) ? out_byte[1] : out_byte[0];
   logic drive;
   always_ff @(posedge clock) begin
      if (rst) begin
         port_bus_out <= 8'h00;
         drive <= 1'b0;
      end else begin
         drive <= m_rd;
         if (m_rd) port_bus_out <= m_rd_mux;
      end
   end
   assign port_bus_oe_n = !(drive && m_rd);
endmodule
`default_nettype wire

// ---- tb/mbx_port_asserts.sv ----
// Concurrent checks on the mailbox port top-level ports
`timescale 1ns/1ns
`default_nettype none
module mbx_port_asserts
   import mbx_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic reg_read,
   input wire logic reg_write,
   input wire logic port_read_n,
   input wire logic port_write_n,
   input wire logic port_bus_oe_n,
   input wire logic attention_out_n,
   input wire logic port_enabled,
   input wire logic port_pins_own,
   input wire logic [1:0] pin_mode,
   input wire logic irq,
   input wire logic [1:0] irq_priority,
   input wire logic [11:0] irq_vector
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   wire logic lw0 = reg_write && reg_addr == OFS_BYTE_0;
   wire logic lst = reg_write && reg_addr == OFS_STATUS;
   wire logic l_map = reg_addr >= OFS_BYTE_0 && reg_addr <= OFS_STATUS;
   a_oe_enabled: assert property (!port_bus_oe_n |-> port_enabled)
      else $error("bus driven while disabled");
   a_oe_read_only: assert property (port_read_n [*6] |-> port_bus_oe_n)
      else $error("bus driven without read");
   a_attn_off: assert property (!port_enabled |-> attention_out_n)
      else $error("attention while disabled");
   a_attn_set: assert property (lw0 && port_enabled |=> !attention_out_n)
      else $error("attention not raised");
   a_read_clears: assert property (reg_read && !reg_write && l_map |=> attention_out_n)
      else $error("attention kept after read");
   a_irq_ack: assert property (port_write_n [*6] ##0 lst |=> !irq)
      else $error("request kept after ack");
   a_irq_prio: assert property (irq |-> irq_priority != PRI_OFF)
      else $error("request while off");
   a_vector_fixed: assert property (irq_vector == INT_VECTOR_OFS)
      else $error("vector wrong");
   a_mode_own: assert property (port_pins_own == (pin_mode == MODE_SLAVE))
      else $error("pin ownership wrong");
   a_reset_idle: assert property (disable iff (1'b0) rst |=> attention_out_n && !irq)
      else $error("outputs busy after reset");
   c_irq: cover property ($rose(irq));
   c_attn: cover property ($fell(attention_out_n));
   c_drive: cover property (!port_bus_oe_n);
endmodule
bind mbx_port mbx_port_asserts chk_u (.clock, .rst, .reg_addr, .reg_read, .reg_write,
   .port_read_n, .port_write_n, .port_bus_oe_n, .attention_out_n, .port_enabled,
   .port_pins_own, .pin_mode, .irq, .irq_priority, .irq_vector);
`default_nettype wire

// ---- tb/mbx_master_model.sv ----
// External master model driving the mailbox port pins
`timescale 1ns/1ns
`default_nettype none
module mbx_master_model (
   input wire logic clock,
   input wire logic [7:0] dev_out,
   input wire logic dev_oe_n,
   output logic [7:0] bus,
   output logic [1:0] addr,
   output logic read_n,
   output logic write_n,
   output logic select_n
);
   logic [7:0] drv = 8'h00;
   logic [7:0] last = 8'h00;
   logic drv_en = 1'b0;
   // Floating bus shows the inverse of its last level
   assign bus = !dev_oe_n ? dev_out : drv_en ? drv : ~last;
   always @(posedge clock) last <= bus;
   initial begin
      addr = 2'h0;
      {read_n, write_n, select_n} = 3'h7;
   end
   task automatic access(input logic w, input logic [1:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge clock);
      #2;
      addr = a;
      drv = d;
      drv_en = w;
      select_n = 1'b0;
      read_n = w;
      write_n = !w;
      repeat (6) @(posedge clock);
      q = bus;
      #2;
      {read_n, write_n, select_n, drv_en} = 4'he;
      repeat (4) @(posedge clock);
   endtask
   task automatic poll(output logic [7:0] q, output logic ok);
      logic [7:0] p;
      ok = 1'b0;
      access(0, 2'h3, 8'h00, p);
      for (int i = 0; i < 8; i++) begin
         access(0, 2'h3, 8'h00, q);
         if (q === p) begin
            ok = 1'b1;
            break;
         end
         p = q;
      end
   endtask
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
// Self-checking bench for the mailbox port
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   import mbx_pkg::*;
   logic clock = 0, rst = 1, reg_read = 0, reg_write = 0, use_alt = 0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, bus, bus_out, q;
   logic [1:0] addr, pin_mode, irq_priority;
   logic oe_n, rd_n, wr_n, sel_n, attn_n, en, own, ign, irq, ok;
   logic [11:0] vec;
   int n_mismatch = 0;
   int checks_done = 0;
   mbx_port dut_u (.clock, .rst, .reg_addr, .reg_read, .reg_write, .reg_wdata, .reg_rdata,
      .port_bus_in(bus), .port_bus_out(bus_out), .port_bus_oe_n(oe_n), .port_addr(addr),
      .port_read_n(rd_n), .port_write_n(wr_n), .port_select_n(use_alt | sel_n),
      .alt_select_n(!use_alt | sel_n), .attention_out_n(attn_n), .boot_select_pins(2'h2),
      .port_enabled(en), .port_pins_own(own), .pin_mode, .ignore_boot_pins(ign), .irq,
      .irq_priority, .irq_vector(vec));
   mbx_master_model mst_u (.clock, .dev_out(bus_out), .dev_oe_n(oe_n), .bus, .addr,
      .read_n(rd_n), .write_n(wr_n), .select_n(sel_n));
   initial forever #25 clock = ~clock;
   task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic loc(input logic w, input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      #2;
      reg_addr = a;
      reg_wdata = d;
      reg_write = w;
      reg_read = !w;
      @(posedge clock);
      #2;
      {reg_write, reg_read} = 2'h0;
      q = reg_rdata;
   endtask
   task automatic t_reset;
      loc(0, OFS_STATUS, 8'h00);
      chk("status", q, STATUS_RESET);
      chk("attn reset", attn_n, 1'b1);
      chk("oe reset", oe_n, 1'b1);
      chk("vector lo", vec[7:0], INT_VECTOR_OFS[7:0]);
      chk("vector hi", {4'h0, vec[11:8]}, {4'h0, INT_VECTOR_OFS[11:8]});
      loc(0, OFS_CONTROL, 8'h00);
      chk("control", q, 8'h40);
      mst_u.access(1, SLOT_0, 8'h11, q);
      loc(0, OFS_STATUS, 8'h00);
      chk("status off", q, 8'h00);
      chk("irq off", irq, 1'b0);
      $display("test reset done");
   endtask
   task automatic t_modes;
      for (int m = 0; m < 4; m++) begin
         loc(1, OFS_CONTROL, {4'h0, m[1:0], m[1:0]});
         chk("mode", pin_mode, m[1:0]);
         chk("pri each", irq_priority, m[1:0]);
         chk("enable", en, m == 2);
         chk("own", own, m == 2);
      end
      loc(1, OFS_CONTROL, 8'h89);
      chk("prio", irq_priority, 2'h1);
      chk("fetch", ign, 1'b1);
      loc(0, OFS_CONTROL, 8'h00);
      chk("ctrl read", q, 8'hc0);
      $display("test modes done");
   endtask
   task automatic t_inbound;
      mst_u.access(1, SLOT_2, 8'ha2, q);
      mst_u.access(1, SLOT_1, 8'ha1, q);
      chk("irq early", irq, 1'b0);
      mst_u.access(1, SLOT_0, 8'ha0, q);
      chk("irq set", irq, 1'b1);
      loc(0, OFS_STATUS, 8'h00);
      chk("in status", q, 8'hf0);
      chk("irq read", irq, 1'b0);
      for (int i = 2; i >= 0; i--) begin
         loc(0, OFS_BYTE_0 + i[7:0], 8'h00);
         chk("in byte", q, 8'ha0 + i[7:0]);
      end
      loc(0, OFS_STATUS, 8'h00);
      chk("in empty", q[6:4], 3'h0);
      $display("test inbound done");
   endtask
   task automatic t_outbound;
      for (int i = 2; i >= 0; i--) loc(1, OFS_BYTE_0 + i[7:0], 8'h50 + i[7:0]);
      chk("attn set", attn_n, 1'b0);
      mst_u.access(1, SLOT_STATUS, 8'hff, q);
      chk("attn ack", attn_n, 1'b1);
      mst_u.poll(q, ok);
      chk("poll settled", ok, 1'b1);
      chk("out status", q[3:0], 4'h7);
      for (int i = 2; i >= 0; i--) begin
         mst_u.access(0, i[1:0], 8'h00, q);
         chk("out byte", q, 8'h50 + i[7:0]);
      end
      loc(0, OFS_STATUS, 8'h00);
      chk("out empty", q[2:0], 3'h0);
      loc(1, OFS_BYTE_0, 8'h66);
      mst_u.access(0, SLOT_1, 8'h00, q);
      chk("attn clear", attn_n, 1'b1);
      $display("test outbound done");
   endtask
   task automatic t_ack;
      mst_u.access(1, SLOT_0, 8'h33, q);
      chk("irq again", irq, 1'b1);
      loc(1, OFS_STATUS, 8'hff);
      chk("irq ack", irq, 1'b0);
      loc(0, OFS_BYTE_0, 8'h00);
      chk("ack keeps", q, 8'h33);
      loc(1, OFS_CONTROL, 8'h08);
      mst_u.access(1, SLOT_0, 8'h34, q);
      chk("irq masked", irq, 1'b0);
      $display("test ack done");
   endtask
   task automatic t_alt;
      loc(1, OFS_CONTROL, 8'h19);
      use_alt = 1;
      mst_u.access(1, SLOT_1, 8'h77, q);
      loc(0, OFS_BYTE_1, 8'h00);
      chk("alt byte", q, 8'h77);
      use_alt = 0;
      mst_u.access(1, SLOT_1, 8'h78, q);
      loc(0, OFS_STATUS, 8'h00);
      chk("main ignored", q[5], 1'b0);
      loc(0, OFS_BYTE_1, 8'h00);
      chk("alt kept", q, 8'h77);
      loc(0, 8'h30, 8'h00);
      chk("unmapped", q, 8'h00);
      $display("test alt done");
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge clock);
      #2;
      rst = 0;
      repeat (3) @(posedge clock);
      t_reset();
      t_modes();
      t_inbound();
      t_outbound();
      t_ack();
      t_alt();
      results();
   end
   initial begin
      repeat (5000) @(posedge clock);
      n_mismatch++;
      results();
   end
endmodule
`default_nettype wire
